// file: verilog/dacrb_top.sv
// control register bank of a single-channel voltage-output converter
// Summary of operation
// - sync-mode bit 0 set: written code waits for a load trigger
// - sync-mode bit 0 clear (default): written code applies at once
// - configuration bit 8 disables the internal reference
// - configuration bit 0 powers down output, tied to ground by resistor
// - gain bit 8 halves the reference; clear leaves it undivided
// - alarm shuts reference buffer and forces output to zero volts
// - alarm keeps stored code; output resumes with it afterwards
// - gain bit 0 picks buffer gain two (1) or one (0), resets to 1
// - writing 1 to trigger bit 4 loads pending code in sync mode only, self-clearing
// - code 1010 in trigger bits 3..0 resets every register and the output code but not the alarm, self-clearing
// - configuration register at 3h, reset 0000h
// - gain register at 4h, reset 0001h
// - trigger register at 5h, reset 0000h, command fields write-only
// - sync-mode register at 2h, reset 0000h
// - status bit 0 reads 1 while reference alarm is active
`timescale 1ns/10ps
module dacrb_top
    import dacrb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [3:0] rd_addr,
    output logic [15:0] rd_data,
    input wire logic ref_alarm_in,
    output logic reference_power_down,
    output logic reference_enable,
    output logic output_power_down,
    output logic ref_divide,
    output logic output_buffer_gain,
    output logic ref_buffer_off,
    output logic load_strobe,
    output logic soft_reset,
    output logic [15:0] dac_code
);
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] cfg;
        logic [15:0] gain;
        logic [10:0] trig_rsvd;
        logic [15:0] data;
        logic load;
        logic srst;
        logic wr_code;
        logic [2:0] alarm_sync;
        logic alarm;
        logic [15:0] rd;
    } dacrb_state_t;

    dacrb_state_t s_q, s_d;
    dacrb_out_if ifc();

    // alarm arrives from analog comparator: three stages, settle on agreement
    always_comb
    begin
        s_d = s_q;
        s_d.load = 1'b0;                            // strobe clears itself
        s_d.srst = 1'b0;                            // reset code clears itself
        s_d.wr_code = 1'b0;
        s_d.alarm_sync = {s_q.alarm_sync[1:0], ref_alarm_in};
        if (s_q.alarm_sync[2] == s_q.alarm_sync[1])
            s_d.alarm = s_q.alarm_sync[2];
        if (s_q.srst)
        begin
            // soft reset restores every register; alarm tracks the pin still
            s_d.mode = DACRB_RST_MODE;
            s_d.cfg = DACRB_RST_CFG;
            s_d.gain = DACRB_RST_GAIN;
            s_d.trig_rsvd = DACRB_RST_TRIG[15:5];
            s_d.data = DACRB_RST_DATA;
        end
        else if (wr_en)
        begin
            case (wr_addr)
                DACRB_OFF_MODE: s_d.mode = wr_data;
                DACRB_OFF_CFG: s_d.cfg = wr_data;
                DACRB_OFF_GAIN: s_d.gain = wr_data;
                DACRB_OFF_TRIG:
                begin
                    s_d.trig_rsvd = wr_data[15:5];
                    s_d.load = wr_data[DACRB_BIT_LOAD];
                    s_d.srst = (wr_data[3:0] == DACRB_SOFT_RESET_CODE);
                end
                DACRB_OFF_DATA:
                begin
                    s_d.data = wr_data;             // alarm never blocks this
                    s_d.wr_code = 1'b1;
                end
                default: ;
            endcase
        end
        // read mux; command fields of the trigger read back as zero
        case (rd_addr)
            DACRB_OFF_MODE: s_d.rd = s_d.mode;
            DACRB_OFF_CFG: s_d.rd = s_d.cfg;
            DACRB_OFF_GAIN: s_d.rd = s_d.gain;
            DACRB_OFF_TRIG: s_d.rd = {s_d.trig_rsvd, 5'h00};
            DACRB_OFF_STAT: s_d.rd = {15'h0000, s_d.alarm};
            DACRB_OFF_DATA: s_d.rd = s_d.data;
            default: s_d.rd = 16'h0000;
        endcase
    end

    // reset values are constants; the code register clears on power-up
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
            s_q.gain <= DACRB_RST_GAIN;
        end
        else
            s_q <= s_d;
    end

    assign ifc.write_code = s_q.wr_code;
    assign ifc.load_pulse = s_q.load;
    assign ifc.sync_mode = s_q.mode[DACRB_BIT_SYNC_EN];
    assign ifc.alarm = s_q.alarm;
    assign ifc.code = s_q.data;

    dacrb_out_path u_path (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .soft_rst(s_q.srst),
        .ifc(ifc.path),
        .drive_code(dac_code)
    );

    // analog controls straight from register bits; reference buffer off from the synchronised alarm
    assign rd_data = s_q.rd;
    assign reference_power_down = s_q.cfg[DACRB_BIT_REF_PD];
    assign reference_enable = ~s_q.cfg[DACRB_BIT_REF_PD];
    assign output_power_down = s_q.cfg[DACRB_BIT_OUT_PD];
    assign ref_divide = s_q.gain[DACRB_BIT_REF_DIV];
    assign output_buffer_gain = s_q.gain[DACRB_BIT_GAIN];
    assign ref_buffer_off = s_q.alarm;
    assign load_strobe = s_q.load;
    assign soft_reset = s_q.srst;
endmodule

// file: verilog/dacrb_pkg.sv
// constants for the converter control register bank
package dacrb_pkg;
    localparam int DACRB_AW = 4;
    localparam int DACRB_DW = 16;
    localparam logic [3:0] DACRB_OFF_MODE = 4'h2;
    localparam logic [3:0] DACRB_OFF_CFG = 4'h3;
    localparam logic [3:0] DACRB_OFF_GAIN = 4'h4;
    localparam logic [3:0] DACRB_OFF_TRIG = 4'h5;
    localparam logic [3:0] DACRB_OFF_STAT = 4'h7;
    localparam logic [3:0] DACRB_OFF_DATA = 4'h8;
    localparam int DACRB_BIT_SYNC_EN = 0;
    localparam int DACRB_BIT_REF_PD = 8;
    localparam int DACRB_BIT_OUT_PD = 0;
    localparam int DACRB_BIT_REF_DIV = 8;
    localparam int DACRB_BIT_GAIN = 0;
    localparam int DACRB_BIT_LOAD = 4;
    localparam int DACRB_BIT_ALARM = 0;
    localparam logic [3:0] DACRB_SOFT_RESET_CODE = 4'hA;
    localparam logic [15:0] DACRB_RST_MODE = 16'h0000;
    localparam logic [15:0] DACRB_RST_CFG = 16'h0000;
    localparam logic [15:0] DACRB_RST_GAIN = 16'h0001;
    localparam logic [15:0] DACRB_RST_TRIG = 16'h0000;
    localparam logic [15:0] DACRB_RST_DATA = 16'h0000;
endpackage

// file: verilog/dacrb_out_if.sv
// register-bank to output-path signals
`timescale 1ns/10ps
interface dacrb_out_if;
    logic write_code;
    logic load_pulse;
    logic sync_mode;
    logic alarm;
    logic [15:0] code;
    modport bank (output write_code, output load_pulse, output sync_mode, output alarm,
        output code);
    modport path (input write_code, input load_pulse, input sync_mode, input alarm,
        input code);
endinterface

// file: verilog/dacrb_out_path.sv
// output code latch: immediate or load-triggered update, alarm forcing
`timescale 1ns/10ps
module dacrb_out_path
    import dacrb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic soft_rst,
    dacrb_out_if.path ifc,
    output logic [15:0] drive_code
);
    typedef struct packed {
        logic [15:0] active;
    } dacrb_path_t;
    dacrb_path_t s_q, s_d;

    // pick the code the converter actually uses
    always_comb
    begin
        s_d = s_q;
        if (soft_rst)
            s_d.active = DACRB_RST_DATA;
        else if (ifc.write_code && !ifc.sync_mode)
            s_d.active = ifc.code;
        else if (ifc.load_pulse && ifc.sync_mode)
            s_d.active = ifc.code;
        // a load in immediate mode changes nothing
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // alarm zeroes the drive but keeps the held code
    assign drive_code = ifc.alarm ? 16'h0000 : s_q.active;
endmodule

// file: dv/dacrb_host_model.sv
// host model: register write port and analog alarm level
`timescale 1ns/10ps
module dacrb_host_model
(
    input wire logic sys_clk,
    output logic wr_en = 1'b0,
    output logic [3:0] wr_addr = 4'h0,
    output logic [15:0] wr_data = 16'h0000,
    output logic ref_alarm_in = 1'b0
);
    // hold the write over its edge, then scramble so stale data never looks valid
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        #1;
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(posedge sys_clk);
        #1;
        wr_en = 1'b0;
        wr_addr = ~a;
        wr_data = ~d;
    endtask
    // alarm level stands for a divider choice with too little headroom
    task automatic set_alarm(input logic v);
        ref_alarm_in = v;
    endtask
endmodule

// file: dv/dacrb_checker.sv
// port assertions for the converter register bank
`timescale 1ns/10ps
module dacrb_checker
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic reference_power_down,
    input wire logic reference_enable,
    input wire logic output_power_down,
    input wire logic ref_divide,
    input wire logic output_buffer_gain,
    input wire logic ref_buffer_off,
    input wire logic load_strobe,
    input wire logic soft_reset,
    input wire logic [15:0] dac_code
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // writes in the soft-reset cycle are dropped, so they are left out
    property p_load;
        wr_en && wr_addr == 4'h5 && wr_data[4] && !soft_reset |=> load_strobe;
    endproperty
    a_load: assert property (p_load) else $error("load strobe missing");
    property p_srst;
        wr_en && wr_addr == 4'h5 && wr_data[3:0] == 4'hA && !soft_reset |=> soft_reset;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset missing");
    property p_sclr; soft_reset |=> !soft_reset; endproperty
    a_sclr: assert property (p_sclr) else $error("soft reset stuck");
    property p_sval;
        soft_reset |-> ##[0:1] (output_buffer_gain && !ref_divide && !output_power_down);
    endproperty
    a_sval: assert property (p_sval) else $error("defaults not restored");
    property p_ref; reference_enable == !reference_power_down; endproperty
    a_ref: assert property (p_ref) else $error("reference enable wrong");
    property p_alm; ref_buffer_off |-> dac_code == 16'h0000; endproperty
    a_alm: assert property (p_alm) else $error("output not zero in alarm");
    property p_cfg;
        wr_en && wr_addr == 4'h3 && !soft_reset |=>
            {reference_power_down, output_power_down} == {$past(wr_data[8]), $past(wr_data[0])};
    endproperty
    a_cfg: assert property (p_cfg) else $error("power-down bits wrong");
    property p_gain;
        wr_en && wr_addr == 4'h4 && !soft_reset |=>
            {ref_divide, output_buffer_gain} == {$past(wr_data[8]), $past(wr_data[0])};
    endproperty
    a_gain: assert property (p_gain) else $error("gain bits wrong");
endmodule
bind dacrb_top dacrb_checker i_chk (.sys_clk(sys_clk), .resetn(resetn), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .reference_power_down(reference_power_down),
    .reference_enable(reference_enable), .output_power_down(output_power_down),
    .ref_divide(ref_divide), .output_buffer_gain(output_buffer_gain),
    .ref_buffer_off(ref_buffer_off), .load_strobe(load_strobe), .soft_reset(soft_reset),
    .dac_code(dac_code));

// file: dv/dacrb_top_tb_top.sv
// self-checking bench for the converter register bank
`timescale 1ns/10ps
module dacrb_top_tb_top;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] rd_addr = 4'h0;
    logic wr_en, rpd, ren, opd, rdiv, gain, rbo, ld, srst, alm;
    logic [3:0] wr_addr;
    logic [15:0] wr_data, rd_data, dac_code;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    initial forever #2 sys_clk = ~sys_clk;
    dacrb_host_model i_host (.sys_clk(sys_clk), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .ref_alarm_in(alm));
    dacrb_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .ref_alarm_in(alm),
        .reference_power_down(rpd), .reference_enable(ren), .output_power_down(opd),
        .ref_divide(rdiv), .output_buffer_gain(gain), .ref_buffer_off(rbo),
        .load_strobe(ld), .soft_reset(srst), .dac_code(dac_code));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // read data is registered: settled one edge after the address
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        rd_addr = a;
        step(1);
        check(rd_data, exp);
    endtask
    // bounded wait on the synchronised alarm, which takes a few edges
    task automatic wait_alarm(input logic v);
        for (int n = 0; n < 20 && rbo !== v; n++) step(1);
        step(1);
    endtask
    task automatic t_defaults;
        rd(4'h2, 16'h0000);
        rd(4'h3, 16'h0000);
        rd(4'h4, 16'h0001);
        rd(4'h5, 16'h0000);
        rd(4'h6, 16'h0000);
        check({15'h0, gain}, 16'h0001);
        $display("test defaults done");
    endtask
    task automatic t_update;
        i_host.wr(4'h8, 16'h1234);
        step(1);
        check(dac_code, 16'h1234);
        i_host.wr(4'h2, 16'h0001);
        i_host.wr(4'h8, 16'h5678);
        step(1);
        check(dac_code, 16'h1234);
        // pending code differs from the output here, so an obeyed load would show
        i_host.wr(4'h2, 16'h0000);
        i_host.wr(4'h5, 16'h0010);
        step(2);
        check(dac_code, 16'h1234);
        i_host.wr(4'h2, 16'h0001);
        i_host.wr(4'h5, 16'h0010);
        check({15'h0, ld}, 16'h0001);
        step(1);
        check({15'h0, ld}, 16'h0000);
        check(dac_code, 16'h5678);
        rd(4'h5, 16'h0000);
        $display("test update done");
    endtask
    task automatic t_controls;
        i_host.wr(4'h3, 16'h0101);
        check({13'h0, rpd, ren, opd}, 16'h0005);
        i_host.wr(4'h4, 16'h0100);
        check({14'h0, rdiv, gain}, 16'h0002);
        rd(4'h4, 16'h0100);
        i_host.set_alarm(1'b1);
        wait_alarm(1'b1);
        check(dac_code, 16'h0000);
        rd(4'h7, 16'h0001);
        i_host.set_alarm(1'b0);
        wait_alarm(1'b0);
        check(dac_code, 16'h5678);
        i_host.wr(4'h5, 16'h000A);
        check({15'h0, srst}, 16'h0001);
        step(3);
        check({rpd, opd, rdiv, gain, dac_code[11:0]}, 16'h1000);
        rd(4'h2, 16'h0000);
        $display("test controls done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard well above the seventy or so cycles the tests need
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            results();
        end
    end
    initial
    begin
        step(20);
        resetn = 1'b1;
        t_defaults();
        t_update();
        t_controls();
        results();
    end
endmodule
